// ---- core/mul_div_defs.svh ----
`ifndef MUL_DIV_DEFS_SVH
`define MUL_DIV_DEFS_SVH

`define ERR_RANGE 16'h2003
`define ERR_DIV_ZERO 16'h2012
`define ERR_NONE 16'h0000
`define OP_MUL 1'b0
`define OP_DIV 1'b1
`define OPW_16 1'b0
`define OPW_32 1'b1
`define DIV_STEPS 6'h20
`define WORDS_OUT 3'h4

`endif

// ---- core/mul_div_pkg.sv ----
package mul_div_pkg;

    typedef enum logic [3:0] {
        ST_IDLE = 4'b0001,
        ST_CALC = 4'b0010,
        ST_DIV = 4'b0100,
        ST_DONE = 4'b1000
    } state_e;

    typedef struct packed {
        logic is_div;
        logic wide;
        logic pulse;
        logic s1_ok;
        logic s2_ok;
        logic d_ok;
        logic [31:0] s1;
        logic [31:0] s2;
    } request_s;

    typedef struct packed {
        logic [15:0] w3;
        logic [15:0] w2;
        logic [15:0] w1;
        logic [15:0] w0;
    } result_s;

endpackage

// ---- core/result_store.sv ----
`timescale 1ns/10ps
// four destination words, registered read port
module result_store #(
    parameter int WORDS = 4
) (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_wr,
    input wire logic [63:0] i_data,
    output logic [63:0] o_data
);
    logic [15:0] mem_q [WORDS];
    genvar gi;
    generate
        for (gi = 0; gi < WORDS; gi++) begin : g_word
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    mem_q[gi] <= 16'h0000;
                end else if (i_wr) begin
                    mem_q[gi] <= i_data[gi*16 +: 16];
                end
            end
            always_ff @(posedge i_clk) begin
                if (!i_rst_n) begin
                    o_data[gi*16 +: 16] <= 16'h0000;
                end else begin
                    o_data[gi*16 +: 16] <= i_wr ? i_data[gi*16 +: 16]
                                                : mem_q[gi];
                end
            end
        end
    endgenerate
endmodule

// ---- core/signed_mul_div_unit.sv ----
`timescale 1ns/10ps
`include "mul_div_defs.svh"
module signed_mul_div_unit (
    input wire logic i_clk,
    input wire logic i_rst_n,
    input wire logic i_enabling_input_contact,
    input wire mul_div_pkg::request_s i_req,
    input wire logic i_s1_is_counter,
    output logic o_busy,
    output logic o_done,
    output logic [63:0] o_dest,
    output logic o_instruction_error_flag,
    output logic [15:0] o_error_code_word
);

    ////////////////////////////////////////////////////////////////////
    typedef struct packed {
        mul_div_pkg::state_e st;
        logic en_prev;
        mul_div_pkg::request_s req;
        logic n_neg;
        logic d_neg;
        logic [31:0] n_mag;
        logic [31:0] d_mag;
        logic [31:0] quo;
        logic [32:0] rem;
        logic [5:0] step;
        logic [63:0] res;
        logic wr;
        logic busy;
        logic done;
        logic err;
        logic [15:0] code;
    } state_s;

    state_s s_q;
    state_s s_d;
    logic [63:0] store_q;

    logic fire;
    logic [31:0] a;
    logic [31:0] b;
    logic [63:0] prod;
    logic [32:0] trial;
    logic [31:0] qs;
    logic [31:0] rs;

    // extend 16-bit operands so one datapath serves both widths
    always_comb begin
        a = i_req.wide ? i_req.s1 : {{16{i_req.s1[15]}}, i_req.s1[15:0]};
        b = i_req.wide ? i_req.s2 : {{16{i_req.s2[15]}}, i_req.s2[15:0]};
    end

    // level variant starts in every idle cycle contact is on; pulse only on rise
    assign fire = i_enabling_input_contact
                  && (!i_req.pulse || !s_q.en_prev);

    always_comb begin
        // widen first so no tool forms a 32-bit product
        prod = $signed({{32{s_q.req.s1[31]}}, s_q.req.s1})
               * $signed({{32{s_q.req.s2[31]}}, s_q.req.s2});
        trial = {s_q.rem[31:0], s_q.n_mag[31]} - {1'b0, s_q.d_mag};
        qs = s_q.n_neg ^ s_q.d_neg ? 32'(-s_q.quo) : s_q.quo;
        rs = s_q.n_neg ? 32'(-s_q.rem[31:0]) : s_q.rem[31:0];
    end

    ////////////////////////////////////////////////////////////////////
    always_comb begin
        s_d = s_q;
        s_d.en_prev = i_enabling_input_contact;
        s_d.wr = 1'b0;
        s_d.done = 1'b0;
        case (s_q.st)
            mul_div_pkg::ST_IDLE: begin
                if (fire) begin
                    // a 16-bit form given a counter is a bad device
                    if (!i_req.s1_ok || !i_req.s2_ok || !i_req.d_ok
                        || (i_s1_is_counter && !i_req.wide)) begin
                        s_d.err = 1'b1;
                        s_d.code = `ERR_RANGE;
                        s_d.done = 1'b1;
                    end else if (i_req.is_div && b == 32'h00000000) begin
                        s_d.err = 1'b1;
                        s_d.code = `ERR_DIV_ZERO;
                        s_d.done = 1'b1;
                    end else begin
                        s_d.err = 1'b0;
                        s_d.code = `ERR_NONE;
                        s_d.req = i_req;
                        s_d.req.s1 = a;
                        s_d.req.s2 = b;
                        s_d.n_neg = a[31];
                        s_d.d_neg = b[31];
                        s_d.n_mag = a[31] ? 32'(-a) : a;
                        s_d.d_mag = b[31] ? 32'(-b) : b;
                        s_d.quo = 32'h00000000;
                        s_d.rem = 33'h000000000;
                        s_d.step = `DIV_STEPS;
                        s_d.busy = 1'b1;
                        s_d.st = i_req.is_div ? mul_div_pkg::ST_DIV
                                              : mul_div_pkg::ST_CALC;
                    end
                end
            end
            mul_div_pkg::ST_CALC: begin
                // sign-extended operands make the 64-bit product fit both
                if (s_q.req.wide) begin
                    s_d.res = prod;
                end else begin
                    s_d.res = {32'h00000000, prod[31:0]};
                end
                s_d.st = mul_div_pkg::ST_DONE;
            end
            mul_div_pkg::ST_DIV: begin
                // restoring divide on magnitudes, one bit a cycle
                if (!trial[32]) begin
                    s_d.rem = trial;
                end else begin
                    s_d.rem = {s_q.rem[31:0], s_q.n_mag[31]};
                end
                s_d.quo = {s_q.quo[30:0], !trial[32]};
                s_d.n_mag = {s_q.n_mag[30:0], 1'b0};
                s_d.step = s_q.step - 6'h01;
                if (s_q.step == 6'h01) begin
                    s_d.st = mul_div_pkg::ST_DONE;
                end
            end
            mul_div_pkg::ST_DONE: begin
                if (s_q.req.is_div) begin
                    if (s_q.req.wide) begin
                        s_d.res = {rs, qs};
                    end else begin
                        s_d.res = {32'h00000000, rs[15:0], qs[15:0]};
                    end
                end
                s_d.wr = 1'b1;
                s_d.busy = 1'b0;
                s_d.done = 1'b1;
                s_d.st = mul_div_pkg::ST_IDLE;
            end
            default: begin
                s_d.st = mul_div_pkg::ST_IDLE;
            end
        endcase
    end

    always_ff @(posedge i_clk) begin
        if (!i_rst_n) begin
            s_q <= '0;
            s_q.st <= mul_div_pkg::ST_IDLE;
            // contact held through reset is no rising edge
            s_q.en_prev <= i_enabling_input_contact;
        end else begin
            s_q <= s_d;
        end
    end

    // registered destination words; skipped operations leave them alone
    result_store #(
        .WORDS(`WORDS_OUT)
    ) u_store (
        .i_clk(i_clk),
        .i_rst_n(i_rst_n),
        .i_wr(s_d.wr),
        .i_data(s_d.res),
        .o_data(store_q)
    );

    assign o_dest = store_q;
    assign o_busy = s_q.busy;
    assign o_done = s_q.done;
    assign o_instruction_error_flag = s_q.err;
    assign o_error_code_word = s_q.code;

    ////////////////////////////////////////////////////////////////////
    zero_div_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_q.st == mul_div_pkg::ST_IDLE && fire && i_req.is_div
        && i_req.s1_ok && i_req.s2_ok && i_req.d_ok && !i_s1_is_counter
        && b == 32'h0 |=> o_instruction_error_flag
        && o_error_code_word == 16'h2012 && !o_busy)
        else $error("divide by zero not flagged");

    range_err_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_q.st == mul_div_pkg::ST_IDLE && fire && !i_req.d_ok
        |=> o_instruction_error_flag && o_error_code_word == 16'h2003
        && $stable(o_dest))
        else $error("range error not flagged");

    pulse_once_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        i_req.pulse && $past(i_enabling_input_contact) |-> !fire)
        else $error("pulse form fired without rising edge");

    level_fire_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_q.st == mul_div_pkg::ST_IDLE && i_enabling_input_contact
        && !i_req.pulse |=> o_busy || o_done)
        else $error("level form did not fire");

    mul_result_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_q.st == mul_div_pkg::ST_CALC ##1 s_q.st == mul_div_pkg::ST_DONE
        |=> o_dest == $past(s_q.res, 1))
        else $error("product not written");

    mul16_sign_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_q.st == mul_div_pkg::ST_CALC && !s_q.req.wide
        |=> s_q.res[31] == (s_q.req.s1[15] ^ s_q.req.s2[15])
        || s_q.res[31:0] == 32'h0)
        else $error("16-bit product sign wrong");

    div_steps_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        $rose(s_q.st == mul_div_pkg::ST_DIV)
        |-> ##32 s_q.st == mul_div_pkg::ST_DONE ##1 o_done)
        else $error("divide did not finish in 32 steps");

    rem_sign_a: assert property (
        @(posedge i_clk) disable iff (!i_rst_n)
        s_q.st == mul_div_pkg::ST_DONE && s_q.req.is_div && rs != 32'h0
        |-> rs[31] == s_q.n_neg)
        else $error("remainder sign differs from dividend");

endmodule

// ---- tb/signed_mul_div_unit_tb.sv ----
`timescale 1ns/10ps
module signed_mul_div_unit_tb;
    logic i_clk;
    logic i_rst_n;
    logic i_enabling_input_contact;
    mul_div_pkg::request_s i_req;
    logic i_s1_is_counter;
    logic o_busy;
    logic o_done;
    logic [63:0] o_dest;
    logic o_instruction_error_flag;
    logic [15:0] o_error_code_word;
    int error_cnt = 0;
    int checks_done = 0;
    logic signed [15:0] a16, b16;
    logic signed [31:0] a32, b32;
    logic signed [63:0] p64;
    logic [63:0] keep;
    int cnt;
    logic busy0;

    signed_mul_div_unit DUT (.i_clk(i_clk), .i_rst_n(i_rst_n),
        .i_enabling_input_contact(i_enabling_input_contact),
        .i_req(i_req), .i_s1_is_counter(i_s1_is_counter),
        .o_busy(o_busy), .o_done(o_done), .o_dest(o_dest),
        .o_instruction_error_flag(o_instruction_error_flag),
        .o_error_code_word(o_error_code_word));

    initial begin
        i_clk = 1'b0;
        forever #4 i_clk = ~i_clk;
    end
////////////////////////////////////////////////////////////////////////////
    task automatic end_of_test;
        $display("checks %0d mismatches %0d", checks_done, error_cnt);
        if (error_cnt == 0 && checks_done > 0) begin
            $display("Simulation passed");
        end else begin
            $display("Simulation failed");
        end
        $finish;
    endtask

    task automatic check(string n, logic [63:0] seen, logic [63:0] exp);
        checks_done++;
        if (seen !== exp) begin
            error_cnt++;
            $display("[FAIL] %s expected %h seen %h", n, exp, seen);
        end
    endtask

    // one-cycle contact so the level form fires exactly once
    task automatic go(logic d, logic w, logic [2:0] ok, logic c,
                      logic [31:0] a, logic [31:0] b);
        int i;
        @(posedge i_clk);
        i_req <= '{d, w, 1'b0, ok[2], ok[1], ok[0], a, b};
        i_s1_is_counter <= c;
        i_enabling_input_contact <= 1'b1;
        @(posedge i_clk);
        i_enabling_input_contact <= 1'b0;
        // a skipped op pulses done right after the take edge
        for (i = 0; i < 60; i++) begin
            #1;
            if (i == 0) busy0 = o_busy;
            if (o_done === 1'b1) break;
            @(posedge i_clk);
        end
        if (i == 60) begin
            check("done timeout", 1'b0, 1'b1);
            end_of_test();
        end
        check("busy at done", o_busy, 1'b0);
    endtask
////////////////////////////////////////////////////////////////////////////
    task automatic t_mul;
        a16 = 16'shFFFD;
        b16 = 16'sh7FFF;
        a32 = a16 * b16;
        go(1'b0, 1'b0, 3'h7, 1'b0, 32'h0000FFFD, 32'h00007FFF);
        check("mul16 lo", o_dest[15:0], a32[15:0]);
        check("mul16 hi", o_dest[31:16], a32[31:16]);
        check("mul16 sign", o_dest[31], 1'b1);
        check("mul busy", busy0, 1'b1);
        a32 = 32'sh80000000;
        b32 = 32'sh7FFFFFFF;
        p64 = a32 * b32;
        go(1'b0, 1'b1, 3'h7, 1'b0, a32, b32);
        check("mul32", o_dest, p64);
        check("mul32 sign", o_dest[63], 1'b1);
        $display("test mul done");
    endtask

    task automatic t_div;
        a16 = -16'sd7;
        b16 = 16'sd2;
        a32 = {a16 % b16, a16 / b16};
        go(1'b1, 1'b0, 3'h7, 1'b0, 32'h0000FFF9, 32'h00000002);
        check("div16 q", o_dest[15:0], a32[15:0]);
        check("div16 r", o_dest[31:16], a32[31:16]);
        check("div16 hi", o_dest[63:32], 32'h00000000);
        check("div16 err", o_instruction_error_flag, 1'b0);
        a32 = 32'sh80000001;
        b32 = -32'sd16;
        p64 = {a32 % b32, a32 / b32};
        go(1'b1, 1'b1, 3'h7, 1'b0, a32, b32);
        check("div32 q", o_dest[31:0], p64[31:0]);
        check("div32 r", o_dest[63:32], p64[63:32]);
        $display("test div done");
    endtask

    task automatic t_err;
        keep = o_dest;
        go(1'b1, 1'b0, 3'h7, 1'b0, 32'h00000005, 32'h00000000);
        check("div0 flag", o_instruction_error_flag, 1'b1);
        check("div0 code", o_error_code_word, 16'h2012);
        check("div0 dest", o_dest, keep);
        check("div0 busy", busy0, 1'b0);
        go(1'b0, 1'b1, 3'h3, 1'b0, 32'h00000003, 32'h00000004);
        check("range code", o_error_code_word, 16'h2003);
        check("range dest", o_dest, keep);
        check("range flag", o_instruction_error_flag, 1'b1);
        go(1'b0, 1'b0, 3'h7, 1'b1, 32'h00000003, 32'h00000004);
        check("ctr16 code", o_error_code_word, 16'h2003);
        go(1'b0, 1'b1, 3'h7, 1'b1, 32'h00000003, 32'h00000004);
        check("ctr32 code", o_error_code_word, 16'h0000);
        check("ctr32 dest", o_dest, 64'h000000000000000C);
        check("ctr32 flag", o_instruction_error_flag, 1'b0);
        $display("test errors done");
    endtask

    // hold the contact high; pulse form must fire once, level form often
    task automatic t_hold(logic p);
        cnt = 0;
        @(posedge i_clk);
        i_req <= '{1'b1, 1'b0, p, 1'b1, 1'b1, 1'b1, 32'h9, 32'h2};
        i_s1_is_counter <= 1'b0;
        i_enabling_input_contact <= 1'b1;
        repeat (100) begin
            @(posedge i_clk);
            #1;
            cnt += (o_done === 1'b1);
        end
        @(posedge i_clk);
        i_enabling_input_contact <= 1'b0;
        repeat (45) @(posedge i_clk);
        if (p) check("pulse once", cnt, 1);
        else check("level refire", cnt > 1, 1'b1);
        check("hold q", o_dest[31:0], 32'h00010004);
        $display("test hold %0d done", p);
    endtask
////////////////////////////////////////////////////////////////////////////
    initial begin
        i_rst_n = 1'b0;
        i_enabling_input_contact = 1'b0;
        i_req = '0;
        i_s1_is_counter = 1'b0;
        repeat (16) @(posedge i_clk);
        i_rst_n <= 1'b1;
        #1;
        check("reset dest", o_dest, 64'h0);
        check("reset code", o_error_code_word, 16'h0000);
        check("reset flag", o_instruction_error_flag, 1'b0);
        check("reset busy", o_busy, 1'b0);
        t_mul();
        t_div();
        t_err();
        t_hold(1'b1);
        t_hold(1'b0);
        end_of_test();
    end
endmodule
